/* hw/poe_pkg.sv */
// Purpose: shared constants and types of the PoE port sequencer
// Assumes: 10 MHz core clock, 1 ms internal timebase tick
// Notes: detection voltage codes are 10-bit, 20 mV per step
package poe_pkg;
    // clock and timebase
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int MS_W = 13;

    // sequence times, in ms ticks
    localparam int DET_PERIOD_MS = 580;
    localparam int BACKOFF_MS = 3200;
    localparam int SD_DELAY_MS = 4000;
    localparam int ERR_DELAY_MS = 4000;
    localparam int OVLD_MS = 62;
    localparam int MPDO_MS = 350;
    localparam int CLASS_MS = 37;
    localparam int SETTLE_MS = 20;
    localparam int BUDGET_SETTLE_MS = 10;

    // detection measurement scaling
    localparam int V_LSB_MV = 20;
    localparam int I1_UA = 170;
    localparam int I2_UA = 270;
    localparam int SIG_RMIN_OHM = 17000;
    localparam int SIG_RMAX_OHM = 29700;
    localparam int FORCE_VMIN_MV = 1000;
    localparam int FORCE_VMAX_MV = 10000;
    localparam int OPEN_MV = 12000;
    localparam int SHORT_MV = 500;
    localparam logic [9:0] DV_MIN_CODE =
        10'(SIG_RMIN_OHM * (I2_UA - I1_UA) / 1000 / V_LSB_MV);
    localparam logic [9:0] DV_MAX_CODE =
        10'(SIG_RMAX_OHM * (I2_UA - I1_UA) / 1000 / V_LSB_MV);
    localparam logic [9:0] FORCE_VMIN_CODE = 10'(FORCE_VMIN_MV / V_LSB_MV);
    localparam logic [9:0] FORCE_VMAX_CODE = 10'(FORCE_VMAX_MV / V_LSB_MV);
    localparam logic [9:0] OPEN_CODE = 10'(OPEN_MV / V_LSB_MV);
    localparam logic [9:0] SHORT_CODE = 10'(SHORT_MV / V_LSB_MV);

    // indicator timing
    localparam logic [5:0] PWM_PERIOD = 6'h32;
    localparam logic [5:0] PWM_ON = 6'h03;
    localparam int BLINK_MS = 200;
    localparam int PAUSE_MS = 1000;

    // register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic CTRL_EN_RESET = 1'h1;

    // fault codes, also the blink count
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_SIG = 3'h1;
    localparam logic [2:0] FLT_CAP = 3'h2;
    localparam logic [2:0] FLT_BUDGET = 3'h3;
    localparam logic [2:0] FLT_OVLD = 3'h4;

    // budget node current and cut threshold selects
    localparam logic [1:0] BUD_NONE = 2'h0;
    localparam logic [1:0] BUD_C1 = 2'h1;
    localparam logic [1:0] BUD_C2 = 2'h2;
    localparam logic [1:0] BUD_FULL = 2'h3;
    localparam logic [1:0] OVERLOAD_CUT_THRESHOLD_FULL = 2'h0;
    localparam logic [1:0] OVERLOAD_CUT_THRESHOLD_C1 = 2'h1;
    localparam logic [1:0] OVERLOAD_CUT_THRESHOLD_C2 = 2'h2;
    localparam logic [2:0] CLASS_1 = 3'h1;
    localparam logic [2:0] CLASS_2 = 3'h2;

    typedef enum logic [1:0] {RES_VALID, RES_OPEN, RES_SHORT, RES_BAD} sig_res_t;
    typedef enum logic [3:0] {
        ST_SHUT, ST_HOLDOFF, ST_DET1, ST_DET2, ST_EVAL, ST_WAIT,
        ST_CLASS, ST_BUD_CHK, ST_BUD_ADD, ST_ON
    } seq_state_t;
endpackage

/* hw/led_if.sv */
// Purpose: carries port state from the sequencer to the indicator driver
// Assumes: all signals on the core clock
// Notes: tick is the 1 ms timebase pulse
`timescale 1ns/10ps
interface led_if;
    logic port_on;
    logic [2:0] fault;
    logic tick;
    logic single_supply;
    modport ctl (output port_on, output fault, output tick, output single_supply);
    modport drv (input port_on, input fault, input tick, input single_supply);
endinterface

/* hw/poe_led_driver.sv */
// Purpose: open-drain indicator drive, steady, blinking or pulsed
// Assumes: fault code is the number of blinks per burst
// Notes: enable high means the pin is pulled low
`timescale 1ns/10ps
module poe_led_driver (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // state from the sequencer
    led_if.drv led,
    // pin drive
    output logic led_oe
);
    logic [5:0] pwm_r, pwm_nxt;
    logic [10:0] ms_r, ms_nxt;
    logic [3:0] slot_r, slot_nxt;
    logic oe_r, oe_nxt;
    logic [3:0] last_slot;
    logic lit;

    always_comb
    begin
        last_slot = {led.fault, 1'b0};
        pwm_nxt = (pwm_r == poe_pkg::PWM_PERIOD - 6'h01) ? 6'h00 : pwm_r + 6'h01;
        ms_nxt = ms_r;
        slot_nxt = slot_r;
        if (led.fault == poe_pkg::FLT_NONE)
        begin
            ms_nxt = 11'h000;
            slot_nxt = 4'h0;
        end
        else if (led.tick)
        begin
            // burst of blinks, then a long dark pause
            if ((slot_r >= last_slot && ms_r >= 11'(poe_pkg::PAUSE_MS - 1)) ||
                (slot_r < last_slot && ms_r >= 11'(poe_pkg::BLINK_MS - 1)))
            begin
                ms_nxt = 11'h000;
                slot_nxt = (slot_r >= last_slot) ? 4'h0 : slot_r + 4'h1;
            end
            else
            begin
                ms_nxt = ms_r + 11'h001;
            end
        end
        if (led.fault != poe_pkg::FLT_NONE)
            lit = (slot_r < last_slot) && !slot_r[0]; // R2
        else
            lit = led.port_on; // R1
        // short pulses let an inductor feed the led from 48 V cheaply
        oe_nxt = lit && (!led.single_supply || pwm_r < poe_pkg::PWM_ON); // R3
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_r <= 6'h00;
            ms_r <= 11'h000;
            slot_r <= 4'h0;
            oe_r <= 1'b0;
        end
        else
        begin
            pwm_r <= pwm_nxt;
            ms_r <= ms_nxt;
            slot_r <= slot_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign led_oe = oe_r;

    led_dark_a: assert property (@(posedge clk) disable iff (!nrst)
        !led.port_on && led.fault == poe_pkg::FLT_NONE |=> !led_oe) // R1
        else $error("indicator lit with port off and no fault");
    led_duty_a: assert property (@(posedge clk) disable iff (!nrst)
        led_oe && $past(led.single_supply) |-> $past(pwm_r) < poe_pkg::PWM_ON) // R3
        else $error("indicator pulse outside the short duty window");
endmodule

/* hw/poe_port_sequencer.sv */
// Purpose: detect, classify, budget and power one PoE source port
// Assumes: analog converters and dc sense run on CLK; straps and other comparators are async pins
// Notes: all delays come from one 1 ms tick
// Operation
// R1 - pull indicator low while port is powered, release otherwise
// R2 - flash distinct indicator patterns for each kind of port fault
// R3 - on single 48V supply, pulse indicator low at 6% duty when lit
// R4 - legacy strap high also accepts large-capacitance older devices
// R5 - legacy strap low accepts only standard signatures
// R6 - legacy strap floating powers any load reading 1V to 10V
// R7 - backoff strap high waits 3.2 s after failed non-open detection
// R8 - backoff strap low adds no extra delay after failures
// R9 - refuse power when budget node is above 1V before turn-on
// R10 - source budget node current proportional to powered class
// R11 - oscillator pin grounded selects DC disconnect instead of AC
// R12 - AC mode removes power when capacitance stays low past dropout delay
// R13 - shutdown low stops detection and removes port power
// R14 - wait 4 s after shutdown release before first detection
// R15 - enforce strap low keeps full cut threshold; high lowers class 1,2
// R16 - apply two test currents, measure both, subtract for slope
// R17 - settle and measure each point; store first before second current
// R18 - accept signature resistance from 17k to 29.7k ohms
// R19 - flash a code for invalid signatures that are not open or short
// R20 - refuse over 5uF parallel capacitance unless legacy mode is on
// R21 - repeat detection every 580ms, or 3.2s with midspan backoff
// R22 - after valid detection: classify, check budget, then power up
// R23 - budget over after adding current: withdraw, abort, redetect
// R24 - remove power when current exceeds cut threshold over 62ms
// R25 - derive all delays from one free-running internal timebase
`timescale 1ns/10ps
module poe_port_sequencer #(
    parameter int TICK_CYCLES = poe_pkg::TICK_CYCLES
)(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // straps and control pins
    input wire logic SHUTDOWN_N,
    input wire logic LEGACY_HI,
    input wire logic LEGACY_LO,
    input wire logic MIDSPAN,
    input wire logic CLASS_LIMIT_ENFORCE,
    input wire logic DISCONNECT_OSC_GROUNDED,
    input wire logic SINGLE_SUPPLY,
    // comparators from the port front end
    input wire logic BUDGET_OVER,
    input wire logic CAP_LARGE,
    input wire logic AC_SENSE_CAP_LOW,
    input wire logic DC_MPS_LOST,
    input wire logic OVERLOAD,
    // on-chip converters
    input wire logic [9:0] DET_V,
    input wire logic [2:0] CLASS_CODE,
    // port front end control
    output logic DET_EN,
    output logic DET_CUR_SEL,
    output logic CLASS_EN,
    output logic PORT_ON,
    output logic AC_MODE,
    output logic [1:0] BUDGET_CUR_SEL,
    output logic [1:0] OVERLOAD_CUT_THRESHOLD,
    // indicator pin
    output logic LED_O,
    output logic LED_OE
);
    localparam int DIV_W = $clog2(TICK_CYCLES);
    localparam int NPIN = 11;

    logic [NPIN-1:0] sync1_r, sync2_r;
    logic shutdown_n_s, legacy_hi_s, legacy_lo_s, midspan_s, enforce_s, osc_gnd_s;
    logic single_s, budget_over_s, cap_large_s, ac_low_s, dc_lost_s, overload_s;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic tick;
    poe_pkg::seq_state_t state_r, state_nxt;
    logic [poe_pkg::MS_W-1:0] ms_r, ms_nxt, wait_lim_r, wait_lim_nxt;
    logic [9:0] v1_r, v1_nxt, v2_r, v2_nxt;
    logic [2:0] class_r, class_nxt, fault_r, fault_nxt;
    logic [6:0] ovld_r, ovld_nxt;
    logic [8:0] disc_r, disc_nxt;
    poe_pkg::sig_res_t res;
    logic ctrl_en_r, ctrl_en_nxt, enabled, disc_cond;
    logic [31:0] rdata_r, rdata_nxt;

    led_if led ();

    // classify the two-point measurement
    function automatic poe_pkg::sig_res_t sig_eval(input logic [9:0] v1, input logic [9:0] v2,
                                                  input logic hi, input logic lo,
                                                  input logic cap);
        logic [9:0] dv;
        dv = v2 - v1; // R16
        if (!hi && !lo)
            sig_eval = (v2 >= poe_pkg::FORCE_VMIN_CODE && v2 <= poe_pkg::FORCE_VMAX_CODE) ?
                       poe_pkg::RES_VALID : poe_pkg::RES_BAD; // R6
        else if (v2 >= poe_pkg::OPEN_CODE)
            sig_eval = poe_pkg::RES_OPEN;
        else if (v2 < poe_pkg::SHORT_CODE)
            sig_eval = poe_pkg::RES_SHORT;
        else if (v2 > v1 && dv >= poe_pkg::DV_MIN_CODE && dv <= poe_pkg::DV_MAX_CODE &&
                 (!cap || hi)) // R4 R5 R18 R20
            sig_eval = poe_pkg::RES_VALID;
        else
            sig_eval = poe_pkg::RES_BAD;
    endfunction

    // class to budget current; class 0, 3 and 4 all take full power
    function automatic logic [1:0] bud_sel(input logic [2:0] cls);
        if (cls == poe_pkg::CLASS_1)
            bud_sel = poe_pkg::BUD_C1;
        else if (cls == poe_pkg::CLASS_2)
            bud_sel = poe_pkg::BUD_C2;
        else
            bud_sel = poe_pkg::BUD_FULL;
    endfunction

    // pin synchroniser
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {SHUTDOWN_N, LEGACY_HI, LEGACY_LO, MIDSPAN, CLASS_LIMIT_ENFORCE,
                        DISCONNECT_OSC_GROUNDED, SINGLE_SUPPLY, BUDGET_OVER, CAP_LARGE,
                        AC_SENSE_CAP_LOW, OVERLOAD};
            sync2_r <= sync1_r;
        end
    end

    assign {shutdown_n_s, legacy_hi_s, legacy_lo_s, midspan_s, enforce_s, osc_gnd_s,
            single_s, budget_over_s, cap_large_s, ac_low_s, overload_s} = sync2_r;
    // dc sense comes from on-chip logic on CLK
    assign dc_lost_s = DC_MPS_LOST;

    // free-running 1 ms timebase
    always_comb
    begin
        tick = (div_r == DIV_W'(TICK_CYCLES - 1)); // R25
        div_nxt = tick ? '0 : div_r + DIV_W'(1);
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            div_r <= '0;
        else
            div_r <= div_nxt;
    end

    assign enabled = shutdown_n_s && ctrl_en_r;
    assign disc_cond = osc_gnd_s ? dc_lost_s : ac_low_s; // R11
    assign res = sig_eval(v1_r, v2_r, legacy_hi_s, legacy_lo_s, cap_large_s);

    // port sequence
    always_comb
    begin
        state_nxt = state_r;
        wait_lim_nxt = wait_lim_r;
        v1_nxt = v1_r;
        v2_nxt = v2_r;
        class_nxt = class_r;
        fault_nxt = fault_r;
        ovld_nxt = 7'h00;
        disc_nxt = 9'h000;
        case (state_r)
            poe_pkg::ST_SHUT:
            begin
                state_nxt = poe_pkg::ST_HOLDOFF;
                wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::SD_DELAY_MS); // R14
            end
            poe_pkg::ST_HOLDOFF, poe_pkg::ST_WAIT:
            begin
                if (ms_r >= wait_lim_r)
                    state_nxt = poe_pkg::ST_DET1;
            end
            poe_pkg::ST_DET1:
            begin
                if (ms_r >= poe_pkg::MS_W'(poe_pkg::SETTLE_MS))
                begin
                    v1_nxt = DET_V; // R17
                    state_nxt = poe_pkg::ST_DET2;
                end
            end
            poe_pkg::ST_DET2:
            begin
                if (ms_r >= poe_pkg::MS_W'(poe_pkg::SETTLE_MS))
                begin
                    v2_nxt = DET_V; // R16
                    state_nxt = poe_pkg::ST_EVAL;
                end
            end
            poe_pkg::ST_EVAL:
            begin
                if (res == poe_pkg::RES_VALID)
                begin
                    fault_nxt = poe_pkg::FLT_NONE;
                    state_nxt = poe_pkg::ST_CLASS; // R22
                end
                else
                begin
                    state_nxt = poe_pkg::ST_WAIT;
                    if (res == poe_pkg::RES_BAD)
                        fault_nxt = (cap_large_s && !legacy_hi_s) ?
                                    poe_pkg::FLT_CAP : poe_pkg::FLT_SIG; // R19 R20
                    else
                        fault_nxt = poe_pkg::FLT_NONE;
                    if (midspan_s && res != poe_pkg::RES_OPEN)
                        wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::BACKOFF_MS); // R7 R21
                    else
                        wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::DET_PERIOD_MS); // R8 R21
                end
            end
            poe_pkg::ST_CLASS:
            begin
                if (ms_r >= poe_pkg::MS_W'(poe_pkg::CLASS_MS))
                begin
                    class_nxt = CLASS_CODE;
                    state_nxt = poe_pkg::ST_BUD_CHK; // R22
                end
            end
            poe_pkg::ST_BUD_CHK:
            begin
                wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::DET_PERIOD_MS);
                if (budget_over_s)
                begin
                    fault_nxt = poe_pkg::FLT_BUDGET;
                    state_nxt = poe_pkg::ST_WAIT; // R9
                end
                else
                    state_nxt = poe_pkg::ST_BUD_ADD;
            end
            poe_pkg::ST_BUD_ADD:
            begin
                if (ms_r >= poe_pkg::MS_W'(poe_pkg::BUDGET_SETTLE_MS))
                begin
                    if (budget_over_s)
                    begin
                        fault_nxt = poe_pkg::FLT_BUDGET;
                        state_nxt = poe_pkg::ST_WAIT; // R23
                    end
                    else
                        state_nxt = poe_pkg::ST_ON; // R22
                end
            end
            poe_pkg::ST_ON:
            begin
                ovld_nxt = overload_s ? ovld_r + {6'h00, tick} : 7'h00;
                disc_nxt = disc_cond ? disc_r + {8'h00, tick} : 9'h000;
                if (ovld_r >= 7'(poe_pkg::OVLD_MS))
                begin
                    fault_nxt = poe_pkg::FLT_OVLD;
                    wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::ERR_DELAY_MS);
                    state_nxt = poe_pkg::ST_HOLDOFF; // R24
                end
                else if (disc_r >= 9'(poe_pkg::MPDO_MS))
                begin
                    wait_lim_nxt = poe_pkg::MS_W'(poe_pkg::DET_PERIOD_MS);
                    state_nxt = poe_pkg::ST_WAIT; // R12
                end
            end
            default:
                state_nxt = poe_pkg::ST_SHUT;
        endcase
        if (!enabled)
        begin
            state_nxt = poe_pkg::ST_SHUT; // R13
            fault_nxt = poe_pkg::FLT_NONE;
        end
        // the timer restarts on every state change
        if (state_nxt != state_r)
            ms_nxt = '0;
        else if (tick && ms_r != '1)
            ms_nxt = ms_r + poe_pkg::MS_W'(1); // R25
        else
            ms_nxt = ms_r;
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_r <= poe_pkg::ST_SHUT;
            ms_r <= '0;
            wait_lim_r <= '0;
            v1_r <= 10'h000;
            v2_r <= 10'h000;
            class_r <= 3'h0;
            fault_r <= poe_pkg::FLT_NONE;
            ovld_r <= 7'h00;
            disc_r <= 9'h000;
        end
        else
        begin
            state_r <= state_nxt;
            ms_r <= ms_nxt;
            wait_lim_r <= wait_lim_nxt;
            v1_r <= v1_nxt;
            v2_r <= v2_nxt;
            class_r <= class_nxt;
            fault_r <= fault_nxt;
            ovld_r <= ovld_nxt;
            disc_r <= disc_nxt;
        end
    end

    // front end drive, decoded from the state and class registers and the synchronised straps
    assign DET_EN = (state_r == poe_pkg::ST_DET1) || (state_r == poe_pkg::ST_DET2);
    assign DET_CUR_SEL = (state_r == poe_pkg::ST_DET2); // R16
    assign CLASS_EN = (state_r == poe_pkg::ST_CLASS);
    assign PORT_ON = (state_r == poe_pkg::ST_ON);
    assign AC_MODE = !osc_gnd_s; // R11
    assign BUDGET_CUR_SEL = (state_r == poe_pkg::ST_BUD_ADD || state_r == poe_pkg::ST_ON) ?
                            bud_sel(class_r) : poe_pkg::BUD_NONE; // R10
    assign OVERLOAD_CUT_THRESHOLD = !enforce_s ? poe_pkg::OVERLOAD_CUT_THRESHOLD_FULL :
                                    (class_r == poe_pkg::CLASS_1) ? poe_pkg::OVERLOAD_CUT_THRESHOLD_C1 :
                                    (class_r == poe_pkg::CLASS_2) ? poe_pkg::OVERLOAD_CUT_THRESHOLD_C2 :
                                    poe_pkg::OVERLOAD_CUT_THRESHOLD_FULL; // R15

    // register port; data stands only in the cycle after the read
    always_comb
    begin
        ctrl_en_nxt = ctrl_en_r;
        if (WR && ADDR == poe_pkg::REG_CTRL)
            ctrl_en_nxt = WDATA[0];
        rdata_nxt = 32'h0000_0000;
        if (RD && ADDR == poe_pkg::REG_CTRL)
            rdata_nxt = {31'h0000_0000, ctrl_en_r};
        else if (RD && ADDR == poe_pkg::REG_STATUS)
            rdata_nxt = {21'h00_0000, state_r, class_r, fault_r, PORT_ON};
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl_en_r <= poe_pkg::CTRL_EN_RESET;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctrl_en_r <= ctrl_en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // indicator
    assign led.port_on = PORT_ON;
    assign led.fault = fault_r;
    assign led.tick = tick;
    assign led.single_supply = single_s;
    assign LED_O = 1'b0;

    poe_led_driver led_drv (
        .clk(CLK),
        .nrst(NRST),
        .led(led.drv),
        .led_oe(LED_OE)
    );

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    detect_first_a: assert property (state_r == poe_pkg::ST_DET1 |-> DET_EN && !DET_CUR_SEL) // R16
        else $error("first test point not on the first current");
    store_first_a: assert property (state_r == poe_pkg::ST_DET1 &&
        state_nxt == poe_pkg::ST_DET2 |=> v1_r == $past(DET_V)) // R17
        else $error("first point not stored before second current");
    shut_off_a: assert property (!shutdown_n_s |=> !PORT_ON && !DET_EN) // R13
        else $error("port active during shutdown");
    holdoff_a: assert property (state_r == poe_pkg::ST_SHUT && state_nxt == poe_pkg::ST_HOLDOFF
        |=> wait_lim_r == poe_pkg::MS_W'(poe_pkg::SD_DELAY_MS)) // R14
        else $error("wrong delay after shutdown release");
    budget_refuse_a: assert property (state_r == poe_pkg::ST_BUD_CHK && budget_over_s
        |=> !PORT_ON ##1 !PORT_ON) // R9
        else $error("port powered with budget node over");
    budget_withdraw_a: assert property (state_r == poe_pkg::ST_BUD_ADD &&
        state_nxt == poe_pkg::ST_WAIT |=> BUDGET_CUR_SEL == poe_pkg::BUD_NONE) // R23
        else $error("budget current kept after abort");
    power_order_a: assert property ($rose(PORT_ON) |-> $past(state_r) == poe_pkg::ST_BUD_ADD) // R22
        else $error("port powered without class and budget steps");
    overload_cut_a: assert property (PORT_ON && ovld_r >= 7'(poe_pkg::OVLD_MS) |=> !PORT_ON) // R24
        else $error("overload did not remove power");
    backoff_a: assert property (state_r == poe_pkg::ST_EVAL && state_nxt == poe_pkg::ST_WAIT &&
        midspan_s && res != poe_pkg::RES_OPEN
        |=> wait_lim_r == poe_pkg::MS_W'(poe_pkg::BACKOFF_MS)) // R7
        else $error("midspan backoff not applied");
    cut_full_a: assert property (!enforce_s |-> OVERLOAD_CUT_THRESHOLD == poe_pkg::OVERLOAD_CUT_THRESHOLD_FULL) // R15
        else $error("cut threshold lowered without enforcement");
endmodule

/* testbench/pd_model.sv */
// Purpose: powered device on the cable: signature, class and MPS
// Assumes: port voltage follows the forced current at once
// Notes: a released sense line reads as changing junk, never the last code
`timescale 1ns/10ps
module pd_model (
    // clock and bench setup
    input wire logic clk,
    input wire logic [31:0] res_ohm,
    input wire logic [2:0] cls,
    input wire logic mps,
    // port front end
    input wire logic det_en,
    input wire logic det_sel,
    output logic [9:0] det_v,
    output logic [2:0] class_code,
    output logic mps_lost
);
    logic [9:0] junk_r = 10'h2a5;
    logic [31:0] mv;
    always_ff @(posedge clk)
        junk_r <= ~junk_r + 10'h001;
    // 0.2 V diode offset plus r times 170 or 270 uA, in mV
    assign mv = 32'd200 + res_ohm * (det_sel ? 32'd270 : 32'd170) / 32'd1000;
    assign det_v = !det_en ? junk_r : mv > 32'd20460 ? 10'h3ff : 10'(mv / 32'd20);
    assign class_code = cls;
    assign mps_lost = !mps;
endmodule

/* testbench/tb_poe_port_sequencer.sv */
// Purpose: self-checking bench for the PoE port sequencer
// Assumes: a 4-cycle tick keeps the 4 s holdoffs short
// Notes: expected figures come from tick counts and package constants
`timescale 1ns/10ps
module tb_poe_port_sequencer;
    localparam int T = 4;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, sd_n = 1, leg_hi = 0, leg_lo = 1, midspan = 0;
    logic enforce = 1, osc_gnd = 1, single = 0, bud_over = 0, cap_big = 0, ac_low = 0, ovld = 0;
    logic mps = 1, mps_lost, det_en, det_sel, class_en, port_on, ac_mode, led_o, led_oe;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, res = 32'h0, rd_v;
    logic [2:0] cls = 3'h0, class_code;
    logic [9:0] det_v;
    logic [1:0] bud_sel, cut;
    int mismatches = 0, num_checks = 0, n, gap, wg = 0, cnt, seed = 32'h16cc;
    int cr[6] = '{1000, 40000, 1000000, 25000, 25000, 25000};
    int cf[6] = '{1, 1, 7, 2, 0, 3};
    int cg[6] = '{58, 320, 58, 0, 0, 0};
    poe_port_sequencer #(.TICK_CYCLES(T)) dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SHUTDOWN_N(sd_n), .LEGACY_HI(leg_hi),
        .LEGACY_LO(leg_lo), .MIDSPAN(midspan), .CLASS_LIMIT_ENFORCE(enforce),
        .DISCONNECT_OSC_GROUNDED(osc_gnd), .SINGLE_SUPPLY(single), .BUDGET_OVER(bud_over),
        .CAP_LARGE(cap_big), .AC_SENSE_CAP_LOW(ac_low), .DC_MPS_LOST(mps_lost),
        .OVERLOAD(ovld), .DET_V(det_v), .CLASS_CODE(class_code), .DET_EN(det_en),
        .DET_CUR_SEL(det_sel), .CLASS_EN(class_en), .PORT_ON(port_on), .AC_MODE(ac_mode),
        .BUDGET_CUR_SEL(bud_sel), .OVERLOAD_CUT_THRESHOLD(cut), .LED_O(led_o), .LED_OE(led_oe));
    pd_model pd_u (.clk(clk), .res_ohm(res), .cls(cls), .mps(mps), .det_en(det_en),
        .det_sel(det_sel), .det_v(det_v), .class_code(class_code), .mps_lost(mps_lost));
    initial
        forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // w selects port_on, else det_en; n counts the cycles waited
    task automatic wait_for(input int w, input logic lvl, input int lim);
        n = 0;
        while ((w ? port_on : det_en) !== lvl)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim)
            begin
                mismatches++;
                give_verdict();
            end
        end
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rd_v = rdata;
    endtask
    task automatic tick_wait(input int t);
        repeat (t * T) @(posedge clk);
        #1;
    endtask
    // one detection; settles class and budget time before returning
    task automatic attempt(input logic [31:0] r, input logic cap, input logic bud, input int c);
        @(posedge clk);
        res <= r;
        cap_big <= cap;
        bud_over <= bud;
        cls <= 3'(c);
        wait_for(0, 1'b1, 4100 * T);
        gap = n;
        chk(det_sel, 1'b0);
        tick_wait(25);
        chk(det_sel, 1'b1);
        wait_for(0, 1'b0, 40 * T);
        tick_wait(50);
    endtask
    task automatic powered();
        chk(port_on, 1'b1);
        chk(bud_sel, cls == 1 ? 2'h1 : cls == 2 ? 2'h2 : 2'h3);
        chk(cut, !enforce || cls > 2 || cls == 0 ? 2'h0 : 2'(cls));
        chk(led_oe, 1'b1);
    endtask
    task automatic drop();
        @(posedge clk);
        mps <= !osc_gnd;
        ac_low <= !osc_gnd;
        tick_wait(340);
        chk(port_on, 1'b1);
        tick_wait(20);
        chk(port_on, 1'b0);
        @(posedge clk);
        mps <= 1'b1;
        ac_low <= 1'b0;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        attempt(25000, 0, 0, 2);
        chk(32'(gap / (10 * T)), 32'd400);
        powered();
        single <= 1'b1;
        tick_wait(2);
        cnt = 0;
        repeat (500) @(posedge clk) cnt += led_oe;
        chk(32'(cnt), 32'd30);
        single <= 1'b0;
        sd_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(port_on, 1'b0);
        tick_wait(100);
        chk(det_en, 1'b0);
        sd_n <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            enforce <= i[1];
            osc_gnd <= i[0];
            attempt(32'(19000 + ($random(seed) & 32'h1fff)), 0, 0, 3'($random(seed)));
            if (i == 0)
                chk(32'(gap / (10 * T)), 32'd400);
            chk(ac_mode, !osc_gnd);
            powered();
            drop();
        end
        for (int j = 0; j < 6; j++)
        begin
            leg_hi <= (j == 4);
            leg_lo <= (j % 4 != 0);
            midspan <= (j == 1 || j == 2);
            attempt(cr[j], j == 3 || j == 4, j == 5, 1);
            if (wg != 0)
                chk(32'((gap + 51 * T) / (10 * T)), wg);
            wg = cg[j];
            chk(port_on, j == 4);
            rd_reg(poe_pkg::REG_STATUS);
            if (cf[j] != 7)
                chk(32'(rd_v[3:1]), cf[j]);
            if (j == 4)
                drop();
        end
        rd_reg(4'h8);
        chk(rd_v, 32'h0);
        rd_reg(poe_pkg::REG_CTRL);
        chk(rd_v, 32'h1);
        attempt(22000, 0, 0, 1);
        ovld <= 1'b1;
        tick_wait(55);
        ovld <= 1'b0;
        chk(port_on, 1'b1);
        tick_wait(1);
        ovld <= 1'b1;
        tick_wait(70);
        chk(port_on, 1'b0);
        rd_reg(poe_pkg::REG_STATUS);
        chk(32'(rd_v[3:1]), 32'd4);
        give_verdict();
    end
endmodule
